// *** rtl/modem_status_pkg.sv ***
// Purpose: shared constants and carriers for the modem status and scratch logic
// Assumes: 8-bit register port with a 5-bit address, one register per aligned word
// Notes:   the offsets for the three registers are fixed here and used by the register block, the monitor and the bench
package modem_status_pkg;

  // ==========================================================================
  // register port
  // ==========================================================================
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;

  localparam logic [4:0] MODEM_CONTROL_REG_OFS = 5'h10;
  localparam logic [4:0] MODEM_LINE_STATUS_OFS = 5'h18;
  localparam logic [4:0] SCRATCH_BYTE_OFS      = 5'h1C;

  localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
  localparam logic [7:0] SCRATCH_BYTE_RST  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ     = 8'h00;

  // ==========================================================================
  // modem control fields
  // ==========================================================================
  localparam int unsigned MCR_DTR_BIT  = 0;
  localparam int unsigned MCR_RTS_BIT  = 1;
  localparam int unsigned MCR_USER_OUTPUT_ONE_BIT = 2;
  localparam int unsigned MCR_USER_OUTPUT_TWO_BIT = 3;
  localparam int unsigned MCR_LOOP_BIT = 4;
  localparam logic [7:0]  MCR_USED     = 8'h1F;

  // ==========================================================================
  // modem line status fields
  // ==========================================================================
  localparam int unsigned MSR_CHANGE_LSB = 0;
  localparam int unsigned MSR_STATE_LSB  = 4;
  localparam int unsigned MSR_FIELD_W    = 4;

  // inactive level of every active-low handshake line
  localparam logic [3:0] MODEM_IN_IDLE_N = 4'hF;
  localparam logic [3:0] MODEM_STATE_RST = 4'h0;
  localparam logic [3:0] MODEM_CHG_RST   = 4'h0;

  // bit order matches the status register nibbles
  typedef struct packed {
    logic carrier;
    logic ring;
    logic set_ready;
    logic send_clear;
  } modem_lines_s;

  typedef struct packed {
    logic loopback;
    logic user_output_two;
    logic user_output_one;
    logic send_request_ctrl;
    logic data_term_ready;
  } modem_ctrl_s;

endpackage

// *** rtl/pin_sync.sv ***
// Purpose: multi-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, each bit crosses independently
// Notes:   only the last stage is visible outside
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned       WIDTH  = 4,
  parameter int unsigned       STAGES = 2,
  parameter logic [WIDTH-1:0]  RST    = '1
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  // ==========================================================================
  // checks
  // ==========================================================================
  if (STAGES < 2) begin : g_bad_stages
    $error("pin_sync needs at least two stages");
  end

  logic [WIDTH-1:0] stage_q [STAGES];

  // ==========================================================================
  // flop chain
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= RST;
      end
    end else begin
      stage_q[0] <= i_async;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign o_sync = stage_q[STAGES-1];

endmodule

// *** rtl/modem_change_detect.sv ***
// Purpose: tracks the four modem states and reports change events
// Assumes: i_state is already synchronous and in active-high form
// Notes:   ring reports only its trailing edge, the other lines report both edges
`timescale 1ns/100ps
module modem_change_detect (
  input  wire logic                          i_clk,
  input  wire logic                          i_nrst,
  input  wire modem_status_pkg::modem_lines_s i_state,
  output modem_status_pkg::modem_lines_s      o_state,
  output modem_status_pkg::modem_lines_s      o_event
);

  modem_status_pkg::modem_lines_s prev_q;

  // ==========================================================================
  // previous state
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_q <= modem_status_pkg::MODEM_STATE_RST;
    end else begin
      prev_q <= i_state;
    end
  end

  // ==========================================================================
  // events
  // ==========================================================================
  always_comb begin
    o_event.send_clear = i_state.send_clear ^ prev_q.send_clear; // R01
    o_event.set_ready  = i_state.set_ready ^ prev_q.set_ready;   // R02
    // ring pin going 0 to 1 means ring state falling
    o_event.ring       = prev_q.ring & ~i_state.ring;             // R03
    o_event.carrier    = i_state.carrier ^ prev_q.carrier;       // R04
  end

  assign o_state = prev_q;

endmodule

// *** rtl/uart_modem_status_scratch.sv ***
// Purpose: modem control, modem line status and scratch registers of a UART
// Assumes: register port is select/enable/write with an 8-bit data path
// Notes:   read data is captured in the setup cycle and stands in the access cycle
`timescale 1ns/100ps

// Overview of operation
// R01: clear-to-send change sets status bit 0
// R02: data-set-ready change sets status bit 1
// R03: ring pin rising sets status bit 2
// R04: carrier-detect change sets status bit 3
// R05: any change bit raises modem interrupt
// R06: bit 4 is clear-to-send, or DTR in loopback
// R07: bit 5 is data-set-ready, or RTS in loopback
// R08: bit 6 is ring, or user output one looped
// R09: bit 7 is carrier, or user output two looped
// R10: status register ignores software writes
// R11: scratch byte read/write, resets zero, no effect
// R12: loopback disconnects inputs, drives control pins high
// R13: status read clears change bits, new change wins
module uart_modem_status_scratch #(
  parameter int unsigned SYNC_STAGES = 2
) (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_psel,
  input  wire logic       i_penable,
  input  wire logic       i_pwrite,
  input  wire logic [4:0] i_paddr,
  input  wire logic [7:0] i_pwdata,
  output logic      [7:0] o_prdata,
  input  wire logic       i_send_clear_in_n,
  input  wire logic       i_set_ready_in_n,
  input  wire logic       i_ring_in_n,
  input  wire logic       i_carrier_in_n,
  output logic            o_data_term_ready_n,
  output logic            o_send_request_n,
  output logic            o_user_output_one_n,
  output logic            o_user_output_two_n,
  output logic            o_loopback,
  output logic            o_modem_irq
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("SYNC_STAGES must be at least two");
  end

  // ==========================================================================
  // decode helpers
  // ==========================================================================
  function automatic logic hits(input logic [4:0] addr, input logic [4:0] ofs);
    hits = (addr == ofs);
  endfunction

  // ==========================================================================
  // declarations
  // ==========================================================================
  modem_status_pkg::modem_ctrl_s  ctrl_q;
  modem_status_pkg::modem_ctrl_s  ctrl_d;
  modem_status_pkg::modem_lines_s pins_raw_n;
  modem_status_pkg::modem_lines_s pins_sync_n;
  modem_status_pkg::modem_lines_s live_state;
  modem_status_pkg::modem_lines_s state_q;
  modem_status_pkg::modem_lines_s change_ev;
  modem_status_pkg::modem_lines_s change_q;
  modem_status_pkg::modem_lines_s change_d;
  modem_status_pkg::modem_lines_s read_clear_q;

  logic [7:0] scratch_q;
  logic [7:0] msr_view;
  logic [7:0] mcr_view;
  logic [7:0] rdata_d;
  logic [7:0] prdata_q;
  logic       setup_rd;
  logic       access_rd;
  logic       access_wr;
  logic       msr_access_rd;
  logic       irq_q;
  logic [3:0] pins_out_q;

  // ==========================================================================
  // register port phases
  // ==========================================================================
  assign setup_rd  = i_psel & ~i_penable & ~i_pwrite;
  assign access_rd = i_psel & i_penable & ~i_pwrite;
  assign access_wr = i_psel & i_penable & i_pwrite;

  assign msr_access_rd = access_rd & hits(i_paddr, modem_status_pkg::MODEM_LINE_STATUS_OFS);

  // ==========================================================================
  // input synchronisers
  // ==========================================================================
  // one assignment for the whole carrier: member-wise drivers of a packed
  // variable are refused by strict front ends
  assign pins_raw_n = {i_carrier_in_n, i_ring_in_n, i_set_ready_in_n, i_send_clear_in_n};

  pin_sync #(
    .WIDTH  (4),
    .STAGES (SYNC_STAGES),
    .RST    (modem_status_pkg::MODEM_IN_IDLE_N)
  ) u_pin_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async (pins_raw_n),
    .o_sync  (pins_sync_n)
  );

  // ==========================================================================
  // loopback source select
  // ==========================================================================
  // in loopback the pins are ignored entirely; the change detector then
  // follows the looped control bits, so deltas and interrupts still work
  always_comb begin
    if (ctrl_q.loopback) begin                                   // R12
      live_state.send_clear = ctrl_q.data_term_ready;            // R06
      live_state.set_ready  = ctrl_q.send_request_ctrl;          // R07
      live_state.ring       = ctrl_q.user_output_one;            // R08
      live_state.carrier    = ctrl_q.user_output_two;            // R09
    end else begin
      live_state.send_clear = ~pins_sync_n.send_clear;           // R06
      live_state.set_ready  = ~pins_sync_n.set_ready;            // R07
      live_state.ring       = ~pins_sync_n.ring;                 // R08
      live_state.carrier    = ~pins_sync_n.carrier;              // R09
    end
  end

  // ==========================================================================
  // change detection
  // ==========================================================================
  modem_change_detect u_change (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_state (live_state),
    .o_state (state_q),
    .o_event (change_ev)
  );

  // ==========================================================================
  // change flags
  // ==========================================================================
  // only the bits that the reader actually saw are cleared, and a new event
  // in the clearing cycle is kept, so no change is ever lost
  always_comb begin
    change_d = change_q;
    if (msr_access_rd) begin
      change_d = change_q & ~read_clear_q;                       // R13
    end
    change_d = change_d | change_ev;                             // R01 R02 R03 R04
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      change_q <= modem_status_pkg::MODEM_CHG_RST;
    end else begin
      change_q <= change_d;
    end
  end

  // snapshot of the change bits returned by the read in progress
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      read_clear_q <= modem_status_pkg::MODEM_CHG_RST;
    end else if (setup_rd) begin
      read_clear_q <= change_q;
    end
  end

  // ==========================================================================
  // modem status interrupt
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |change_d;                                        // R05
    end
  end

  assign o_modem_irq = irq_q;

  // ==========================================================================
  // modem control register
  // ==========================================================================
  always_comb begin
    ctrl_d = ctrl_q;
    if (access_wr && hits(i_paddr, modem_status_pkg::MODEM_CONTROL_REG_OFS)) begin
      ctrl_d.data_term_ready   = i_pwdata[modem_status_pkg::MCR_DTR_BIT];
      ctrl_d.send_request_ctrl = i_pwdata[modem_status_pkg::MCR_RTS_BIT];
      ctrl_d.user_output_one   = i_pwdata[modem_status_pkg::MCR_USER_OUTPUT_ONE_BIT];
      ctrl_d.user_output_two   = i_pwdata[modem_status_pkg::MCR_USER_OUTPUT_TWO_BIT];
      ctrl_d.loopback          = i_pwdata[modem_status_pkg::MCR_LOOP_BIT];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q <= modem_status_pkg::MODEM_CONTROL_RST[4:0];
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ==========================================================================
  // modem control pins
  // ==========================================================================
  // pins follow the next control value so they settle with the register
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pins_out_q <= modem_status_pkg::MODEM_IN_IDLE_N;
    end else if (ctrl_d.loopback) begin
      pins_out_q <= modem_status_pkg::MODEM_IN_IDLE_N;           // R12
    end else begin
      pins_out_q <= ~{ctrl_d.user_output_two, ctrl_d.user_output_one,
                      ctrl_d.send_request_ctrl, ctrl_d.data_term_ready};
    end
  end

  assign o_data_term_ready_n = pins_out_q[0];
  assign o_send_request_n    = pins_out_q[1];
  assign o_user_output_one_n = pins_out_q[2];
  assign o_user_output_two_n = pins_out_q[3];
  assign o_loopback          = ctrl_q.loopback;

  // ==========================================================================
  // scratch byte
  // ==========================================================================
  // plain storage; nothing else in the block reads it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scratch_q <= modem_status_pkg::SCRATCH_BYTE_RST;           // R11
    end else if (access_wr && hits(i_paddr, modem_status_pkg::SCRATCH_BYTE_OFS)) begin
      scratch_q <= i_pwdata;                                     // R11
    end
  end

  // ==========================================================================
  // read views
  // ==========================================================================
  // status has no write path at all, so writes to its offset are dropped
  assign msr_view = {state_q, change_q};                         // R10
  assign mcr_view = {3'h0, ctrl_q};

  always_comb begin
    rdata_d = modem_status_pkg::UNMAPPED_READ;
    if (hits(i_paddr, modem_status_pkg::MODEM_LINE_STATUS_OFS)) begin
      rdata_d = msr_view;
    end else if (hits(i_paddr, modem_status_pkg::MODEM_CONTROL_REG_OFS)) begin
      rdata_d = mcr_view & modem_status_pkg::MCR_USED;
    end else if (hits(i_paddr, modem_status_pkg::SCRATCH_BYTE_OFS)) begin
      rdata_d = scratch_q;
    end
  end

  // ==========================================================================
  // read data register
  // ==========================================================================
  // captured in the setup cycle: costs nothing on a two-cycle access and
  // keeps the read data port straight off a flop
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prdata_q <= modem_status_pkg::UNMAPPED_READ;
    end else if (setup_rd) begin
      prdata_q <= rdata_d;
    end
  end

  assign o_prdata = prdata_q;

endmodule

// *** verif/modem_partner.sv ***
// Purpose: modem on the far side, drives the active-low handshake pins
// Assumes: the bench asks for line levels in active-high form
// Notes:   pins move just after a falling edge; idle is the inactive level
`timescale 1ns/100ps
module modem_partner (
  input  wire logic                           i_clk,
  input  wire modem_status_pkg::modem_lines_s i_lines,
  output logic                                o_send_clear_n,
  output logic                                o_set_ready_n,
  output logic                                o_ring_n,
  output logic                                o_carrier_n
);
  initial begin
    {o_carrier_n, o_ring_n, o_set_ready_n, o_send_clear_n} = modem_status_pkg::MODEM_IN_IDLE_N;
  end
  always @(negedge i_clk) begin
    {o_carrier_n, o_ring_n, o_set_ready_n, o_send_clear_n} <= ~i_lines;
  end
endmodule

// *** verif/uart_modem_status_scratch_monitor.sv ***
// Purpose: timing checks on the modem status and scratch ports
// Assumes: handshake pins stay put for several cycles between changes
// Notes:   status contents are compared by the bench model
`timescale 1ns/100ps
module uart_modem_status_scratch_monitor (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic       i_pwrite,
  input wire logic [4:0] i_paddr,
  input wire logic [7:0] i_pwdata,
  input wire logic [7:0] o_prdata,
  input wire logic       i_send_clear_in_n,
  input wire logic       i_set_ready_in_n,
  input wire logic       i_ring_in_n,
  input wire logic       i_carrier_in_n,
  input wire logic       o_data_term_ready_n,
  input wire logic       o_send_request_n,
  input wire logic       o_user_output_one_n,
  input wire logic       o_user_output_two_n,
  input wire logic       o_loopback,
  input wire logic       o_modem_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic rd_setup;
  logic rd_stat;
  logic acc_stat;
  logic wr_ctl;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  assign rd_stat  = rd_setup && (i_paddr == modem_status_pkg::MODEM_LINE_STATUS_OFS);
  assign acc_stat = i_psel && i_penable && !i_pwrite
                    && (i_paddr == modem_status_pkg::MODEM_LINE_STATUS_OFS);
  assign wr_ctl   = i_psel && i_penable && i_pwrite
                    && (i_paddr == modem_status_pkg::MODEM_CONTROL_REG_OFS);
  // ==========================================================================
  // change events
  // ==========================================================================
  // sync latency is two edges, the interrupt one more
  property p_cts_irq; $changed(i_send_clear_in_n) && !o_loopback |-> ##[1:6] o_modem_irq; endproperty
  a_cts_irq: assert property (p_cts_irq) else $error("no interrupt on send clear");
  property p_dsr_irq; $changed(i_set_ready_in_n) && !o_loopback |-> ##[1:6] o_modem_irq; endproperty
  a_dsr_irq: assert property (p_dsr_irq) else $error("no interrupt on set ready");
  property p_ring_irq; $rose(i_ring_in_n) && !o_loopback |-> ##[1:6] o_modem_irq; endproperty
  a_ring_irq: assert property (p_ring_irq) else $error("no interrupt on ring end");
  property p_dcd_irq; $changed(i_carrier_in_n) && !o_loopback |-> ##[1:6] o_modem_irq; endproperty
  a_dcd_irq: assert property (p_dcd_irq) else $error("no interrupt on carrier");
  property p_irq_read; rd_stat ##1 (o_prdata[3:0] != 4'h0) |-> o_modem_irq; endproperty
  a_irq_read: assert property (p_irq_read) else $error("change bits without interrupt");
  // the flag drops at the access edge, so the read is one sample back
  property p_irq_fall; $fell(o_modem_irq) |-> $past(acc_stat); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without read");
  // ==========================================================================
  // register port and control pins
  // ==========================================================================
  property p_rd_hold; !rd_setup |=> $stable(o_prdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_lb_pins;
    o_loopback |-> &{o_data_term_ready_n, o_send_request_n, o_user_output_one_n,
                     o_user_output_two_n};
  endproperty
  a_lb_pins: assert property (p_lb_pins) else $error("control pin low in loopback");
  property p_ctl_wr;
    wr_ctl |=> o_loopback == $past(i_pwdata[4]) && ($past(i_pwdata[4]) ||
      {o_user_output_two_n, o_user_output_one_n, o_send_request_n, o_data_term_ready_n}
      == ~$past(i_pwdata[3:0]));
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control write not on pins");
  c_stat_bits: cover property (rd_stat ##1 (o_prdata[3:0] != 4'h0));
  c_loop: cover property ($rose(o_loopback));
  c_irq_fall: cover property ($fell(o_modem_irq));
endmodule
bind uart_modem_status_scratch uart_modem_status_scratch_monitor u_mon (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .i_send_clear_in_n(i_send_clear_in_n), .i_set_ready_in_n(i_set_ready_in_n),
  .i_ring_in_n(i_ring_in_n), .i_carrier_in_n(i_carrier_in_n),
  .o_data_term_ready_n(o_data_term_ready_n), .o_send_request_n(o_send_request_n),
  .o_user_output_one_n(o_user_output_one_n), .o_user_output_two_n(o_user_output_two_n),
  .o_loopback(o_loopback), .o_modem_irq(o_modem_irq));

// *** verif/tb_uart_modem_status_scratch.sv ***
// Purpose: random register and modem traffic against an integer model
// Assumes: each operation settles before the next starts
// Notes:   a second reset runs with modem lines possibly active
`timescale 1ns/100ps
module tb_uart_modem_status_scratch;
  logic                           i_clk, i_nrst, i_psel, i_penable, i_pwrite;
  logic [4:0]                     i_paddr;
  logic [7:0]                     i_pwdata, o_prdata, rd, v;
  logic                           cts_n, dsr_n, ring_n, dcd_n, dtr_n, rts_n, o1_n, o2_n;
  logic                           loopback, irq;
  modem_status_pkg::modem_lines_s lines;
  int                             err_count, total_checks, m_ctl, m_scr, m_chg, m_st, m_lines;
  int unsigned                    seed = 36202;

  uart_modem_status_scratch u_uart_modem_status_scratch (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .i_send_clear_in_n(cts_n), .i_set_ready_in_n(dsr_n), .i_ring_in_n(ring_n),
    .i_carrier_in_n(dcd_n), .o_data_term_ready_n(dtr_n), .o_send_request_n(rts_n),
    .o_user_output_one_n(o1_n), .o_user_output_two_n(o2_n), .o_loopback(loopback),
    .o_modem_irq(irq));
  modem_partner u_modem_partner (.i_clk(i_clk), .i_lines(lines), .o_send_clear_n(cts_n),
    .o_set_ready_n(dsr_n), .o_ring_n(ring_n), .o_carrier_n(dcd_n));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  // ==========================================================================
  // model and helpers
  // ==========================================================================
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // ring flags only when its active state ends
  task automatic apply();
    int n;
    n = m_ctl[4] ? (m_ctl & 15) : m_lines;
    m_chg |= ((m_st ^ n) & 11) | (m_st & ~n & 4);
    m_st = n;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_psel = 1'b1;
    i_pwrite = wr;
    i_paddr = a;
    i_pwdata = d;
    @(negedge i_clk);
    i_penable = 1'b1;
    rd = o_prdata;
    @(negedge i_clk);
    i_psel = 1'b0;
    i_penable = 1'b0;
    repeat (6) @(negedge i_clk);
  endtask
  task automatic rd_status();
    bus(1'b0, modem_status_pkg::MODEM_LINE_STATUS_OFS, 8'h00);
    chk(8'((m_st << 4) | m_chg), rd);
    m_chg = 0;
  endtask
  task automatic scratch_rw(input logic [7:0] d);
    bus(1'b1, modem_status_pkg::SCRATCH_BYTE_OFS, d);
    m_scr = d;
    bus(1'b0, modem_status_pkg::SCRATCH_BYTE_OFS, 8'h00);
    chk(8'(m_scr), rd);
  endtask
  task automatic do_reset();
    i_nrst = 1'b0;
    repeat (5) @(negedge i_clk);
    i_nrst = 1'b1;
    {m_ctl, m_scr, m_chg, m_st} = '0;
    apply();
    repeat (6) @(negedge i_clk);
  endtask
  task automatic summarize();
    $display("total_checks=%0d err_count=%0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    {i_nrst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    lines = '0;
    m_lines = 0;
    for (int r = 0; r < 2; r++) begin
      do_reset();
      bus(1'b0, modem_status_pkg::SCRATCH_BYTE_OFS, 8'h00);
      chk(modem_status_pkg::SCRATCH_BYTE_RST, rd);
      for (int i = 0; i < 150; i++) begin
        v = rnd();
        case (rnd() % 5)
          0: scratch_rw(v);
          1: begin
            bus(1'b1, modem_status_pkg::MODEM_CONTROL_REG_OFS, v);
            m_ctl = v & 31;
            apply();
            bus(1'b0, modem_status_pkg::MODEM_CONTROL_REG_OFS, 8'h00);
            chk(8'(m_ctl), rd);
          end
          2: begin
            @(posedge i_clk);
            lines <= modem_status_pkg::modem_lines_s'(v[3:0]);
            m_lines = v[3:0];
            apply();
            repeat (8) @(negedge i_clk);
          end
          3: begin
            bus(1'b1, modem_status_pkg::MODEM_LINE_STATUS_OFS, v);
            rd_status();
          end
          default: rd_status();
        endcase
        chk({3'h0, m_ctl[4], m_ctl[4] ? 4'hF : ~m_ctl[3:0]},
            {3'h0, loopback, o2_n, o1_n, rts_n, dtr_n});
        chk({7'h0, m_chg != 0}, {7'h0, irq});
      end
      rd_status();
    end
    summarize();
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    summarize();
  end
endmodule
